// ===== src/tos_pkg.sv
// tos_pkg: register map, command values and carrier types of the offload test sequencer
// assumes one word-addressed register port reaches both engine and user register block
// Overview of operation
// - wait for link bit 16 after power-up
// - poll engine busy before any test
// - two engines: one server, one client
// - prefer client mode against a PC
// - user reset, engine reset, params, release, poll
// - invalid inputs abandon test without writes
// - send: tx length, user reset, command 0
// - active open: command 2, poll conn-on high
// - passive open: no command, poll conn-on high
// - packet length, then loops of 4GB at most
// - per loop: data length, send, poll busy
// - close with command 3 after loops
// - receive: user reset, verify enable bit 1
// - receive: poll conn-on until low
// - then wait until fifo count is zero
// - length match before reading verify error
// - duplex: tx length, user reset, command 1/3
// - duplex loops aligned to packet length
// - active close: rx total, write 3, poll low
// - passive close: no command, poll low
// - duplex with a PC: passive, same size
// - duplex repeats until operator cancels
package tos_pkg;
  localparam int unsigned DEV_AW = 12;
  localparam logic [15:0] OFS_ENG_RST = 16'h0000;
  localparam logic [15:0] OFS_ENG_CMD = 16'h0004;
  localparam logic [15:0] OFS_DATA_LEN = 16'h0020;
  localparam logic [15:0] OFS_PKT_LEN = 16'h0028;
  localparam logic [15:0] OFS_TX_LEN = 16'h1000;
  localparam logic [15:0] OFS_USER_CMD = 16'h1004;
  localparam logic [15:0] OFS_USER_RST = 16'h1008;
  localparam logic [15:0] OFS_FIFO_STS = 16'h100C;
  localparam logic [15:0] OFS_RX_LEN = 16'h1010;
  localparam logic [3:0] PARAM_FIRST = 4'h2;
  localparam logic [3:0] PARAM_LAST = 4'hE;
  localparam int unsigned BIT_LINK = 16;
  localparam int unsigned BIT_BUSY = 0;
  localparam int unsigned BIT_VERR = 1;
  localparam int unsigned BIT_CONN = 2;
  localparam int unsigned FIFO_CNT_W = 16;
  localparam logic [31:0] CMD_SEND = 32'h0000_0000;
  localparam logic [31:0] CMD_OPEN = 32'h0000_0002;
  localparam logic [31:0] CMD_CLOSE = 32'h0000_0003;
  localparam logic [31:0] UCMD_TX_START = 32'h0000_0000;
  localparam logic [31:0] UCMD_DPX = 32'h0000_0001;
  localparam logic [31:0] UCMD_DPX_VER = 32'h0000_0003;
  localparam logic [31:0] UCMD_CLOSE = 32'h0000_0003;
  localparam logic [31:0] RST_PULSE = 32'h0000_0001;
  localparam logic [31:0] RST_RELEASE = 32'h0000_0000;
  // largest qword multiple below 4GB, the data length register being 32 bits
  localparam logic [31:0] LOOP_MAX = 32'hFFFF_FFF8;
  localparam int unsigned QW_SHIFT = 3;
  localparam logic [7:0] SW_CTRL = 8'h00;
  localparam logic [7:0] SW_STATUS = 8'h04;
  localparam logic [7:0] SW_SIZE_LO = 8'h08;
  localparam logic [7:0] SW_SIZE_HI = 8'h0C;
  localparam logic [7:0] SW_PKT = 8'h10;
  localparam logic [7:0] SW_RXLEN = 8'h14;
  localparam logic [7:0] SW_LOOPS = 8'h18;
  localparam logic [7:0] SW_PARAM = 8'h40;
  localparam int unsigned CTRL_ACTIVE = 3;
  localparam int unsigned CTRL_VERIFY = 4;
  localparam int unsigned CTRL_CANCEL = 5;
  typedef enum logic [2:0] {OP_NONE, OP_INIT, OP_SEND, OP_RECV, OP_DPX} tos_op_t;
  typedef struct packed {
    logic wr;
    logic [DEV_AW-1:0] addr;
    logic [31:0] data;
  } tos_acc_t;
  typedef struct packed {
    logic wr_en;
    logic rd_req;
    logic [DEV_AW-1:0] addr;
    logic [31:0] wr_data;
    logic [3:0] wr_be;
  } tos_dev_t;
  function automatic logic [DEV_AW-1:0] word_addr(input logic [15:0] ofs);
    return ofs[DEV_AW+1:2];
  endfunction : word_addr
endpackage : tos_pkg

// ===== src/tos_bus_master.sv
// tos_bus_master: one register access at a time on the shared register port
// assumes a write takes one cycle and a read answers with its valid strobe
module tos_bus_master import tos_pkg::*; (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic start,
  input wire tos_acc_t acc,
  input wire logic dev_rd_valid,
  input wire logic [31:0] dev_rd_data,
  output tos_dev_t dev_q,
  output logic done_q,
  output logic [31:0] rd_data_q
);
  logic wait_q;
  wire logic start_wr = start && acc.wr;
  wire logic start_rd = start && !acc.wr;
  // a read with no answer hangs here; the register block always answers
  wire logic rd_back = wait_q && dev_rd_valid;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dev_q <= '0;
      done_q <= 1'b0;
      wait_q <= 1'b0;
      rd_data_q <= '0;
    end else begin
      dev_q.wr_en <= start_wr;
      dev_q.rd_req <= start_rd;
      dev_q.wr_be <= {4{start_wr}};
      if (start) begin
        dev_q.addr <= acc.addr;
        dev_q.wr_data <= acc.wr ? acc.data : '0;
      end
      wait_q <= start_rd || (wait_q && !dev_rd_valid);
      done_q <= start_wr || rd_back;
      if (rd_back) begin
        rd_data_q <= dev_rd_data;
      end
    end
  end
endmodule : tos_bus_master

// ===== src/tos_loop_split.sv
// tos_loop_split: size of the next send loop from the bytes still to go
// assumes the packet length is nonzero whenever alignment is asked for
module tos_loop_split import tos_pkg::*; #(
  parameter int unsigned SW = 48
) (
  input wire logic [SW-1:0] remain,
  input wire logic [15:0] pkt_len,
  input wire logic align,
  output logic [31:0] chunk,
  output logic last
);
  wire logic [31:0] pkt_ext = {16'h0000, pkt_len};
  wire logic [31:0] pmod = (pkt_len == '0) ? '0 : LOOP_MAX % pkt_ext;
  wire logic [31:0] cap = align ? LOOP_MAX - pmod : LOOP_MAX;
  assign last = remain <= SW'(cap);
  assign chunk = last ? remain[31:0] : cap;
endmodule : tos_loop_split

// ===== src/tos_sequencer.sv
// tos_sequencer: test sequencer driving the offload engine and its user register block
// assumes the device answers reads one cycle after the request, software obeys idle
module tos_sequencer import tos_pkg::*; #(
  parameter int unsigned SIZE_W = 48,
  parameter int unsigned PARAM_N = 16
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata_q,
  output tos_dev_t dev_q,
  input wire logic dev_rd_valid,
  input wire logic [31:0] dev_rd_data
);
  typedef enum logic [4:0] {
    S_LINK, S_IDLE, S_I_URST, S_I_ERST, S_I_PARAM, S_I_EREL, S_I_BUSY,
    S_T_TXLEN, S_T_URST, S_T_UCMD, S_OPEN, S_CONN_ON, S_PKL, S_TDL, S_SEND,
    S_SEND_BUSY, S_CLOSE, S_RX_WAIT, S_FCLOSE, S_CONN_OFF, S_FIFO, S_RXLEN,
    S_VERR, S_FINISH
  } tos_state_t;

  tos_state_t state_q, state_d;
  tos_op_t op_q, req_op;
  logic active_q, verify_q, cancel_q, ready_q, linked_q, conn_q, err_q, done_q;
  logic issued_q, last_q, acc_need, acc_done, split_last;
  logic [SIZE_W-1:0] size_q, remain_q;
  logic [15:0] pkt_q;
  logic [31:0] rx_len_q, loops_q, acc_rd, chunk;
  logic [3:0] pidx_q;
  logic [31:0] param_mem [PARAM_N];
  tos_acc_t acc;

  // software side decode
  assign req_op = tos_op_t'(sw_wdata[2:0]);
  wire logic idle = state_q == S_IDLE;
  wire logic sw_ctrl_wr = sw_wr && sw_addr == SW_CTRL;
  wire logic sw_param = sw_addr[7:6] == SW_PARAM[7:6];
  wire logic go = sw_ctrl_wr && idle && req_op != OP_NONE;
  wire logic [SIZE_W-1:0] qwords = size_q >> QW_SHIFT;
  wire logic [31:0] qw32 = qwords[31:0];
  wire logic size_ok = size_q != '0 && size_q[QW_SHIFT-1:0] == '0
    && (qwords >> 32) == '0;
  wire logic pkt_ok = pkt_q != '0 || req_op == OP_RECV;
  wire logic args_ok = req_op == OP_INIT || (ready_q && size_ok && pkt_ok);
  wire logic is_dpx = op_q == OP_DPX;
  wire logic acc_start = !issued_q && acc_need;
  wire logic stop = cancel_q && !issued_q;

  // answers from the device
  wire logic busy_rd = acc_rd[BIT_BUSY];
  wire logic conn_rd = acc_rd[BIT_CONN];
  wire logic fifo_zero = acc_rd[FIFO_CNT_W-1:0] == '0;
  wire logic rx_match = acc_rd == qw32;

  tos_bus_master u_master (
    .core_clk(core_clk),
    .resetn(resetn),
    .start(acc_start),
    .acc(acc),
    .dev_rd_valid(dev_rd_valid),
    .dev_rd_data(dev_rd_data),
    .dev_q(dev_q),
    .done_q(acc_done),
    .rd_data_q(acc_rd)
  );

  tos_loop_split #(.SW(SIZE_W)) u_split (
    .remain(remain_q),
    .pkt_len(pkt_q),
    .align(is_dpx),
    .chunk(chunk),
    .last(split_last)
  );

  always_comb begin
    state_d = state_q;
    acc_need = 1'b1;
    acc = '{wr: 1'b0, addr: word_addr(OFS_USER_CMD), data: '0};
    case (state_q)
      S_LINK: begin
        acc.addr = word_addr(OFS_USER_RST);
        if (acc_done && acc_rd[BIT_LINK]) state_d = S_IDLE;
      end
      S_IDLE: begin
        acc_need = 1'b0;
        if (go && args_ok) begin
          if (req_op == OP_INIT) state_d = S_I_URST;
          else if (req_op == OP_RECV) state_d = S_T_URST;
          else state_d = S_T_TXLEN;
        end
      end
      S_I_URST: begin
        acc = '{wr: 1'b1, addr: word_addr(OFS_USER_RST), data: RST_PULSE};
        if (acc_done) state_d = S_I_ERST;
      end
      S_I_ERST: begin
        acc = '{wr: 1'b1, addr: word_addr(OFS_ENG_RST), data: RST_PULSE};
        if (acc_done) state_d = S_I_PARAM;
      end
      S_I_PARAM: begin
        // client or server mode rides in a shadow word; software keeps two engines apart
        acc = '{wr: 1'b1, addr: DEV_AW'(pidx_q), data: param_mem[pidx_q]};
        if (acc_done && pidx_q == PARAM_LAST) state_d = S_I_EREL;
      end
      S_I_EREL: begin
        acc = '{wr: 1'b1, addr: word_addr(OFS_ENG_RST), data: RST_RELEASE};
        if (acc_done) state_d = S_I_BUSY;
      end
      S_I_BUSY: begin
        acc.addr = word_addr(OFS_ENG_CMD);
        if (acc_done && !busy_rd) state_d = S_FINISH;
      end
      S_T_TXLEN: begin
        acc = '{wr: 1'b1, addr: word_addr(OFS_TX_LEN), data: qw32};
        if (acc_done) state_d = S_T_URST;
      end
      S_T_URST: begin
        acc = '{wr: 1'b1, addr: word_addr(OFS_USER_RST), data: RST_PULSE};
        if (acc_done) state_d = S_T_UCMD;
      end
      S_T_UCMD: begin
        acc.wr = 1'b1;
        acc.data = (op_q == OP_SEND) ? UCMD_TX_START
          : (verify_q ? UCMD_DPX_VER : UCMD_DPX);
        if (acc_done) state_d = active_q ? S_OPEN : S_CONN_ON;
      end
      S_OPEN: begin
        acc = '{wr: 1'b1, addr: word_addr(OFS_ENG_CMD), data: CMD_OPEN};
        if (acc_done) state_d = S_CONN_ON;
      end
      S_CONN_ON: begin
        if (stop) begin
          acc_need = 1'b0;
          state_d = S_IDLE;
        end else if (acc_done && conn_rd) begin
          state_d = (op_q == OP_RECV) ? S_CONN_OFF : S_PKL;
        end
      end
      S_PKL: begin
        acc = '{wr: 1'b1, addr: word_addr(OFS_PKT_LEN), data: {16'h0000, pkt_q}};
        if (acc_done) state_d = S_TDL;
      end
      S_TDL: begin
        acc = '{wr: 1'b1, addr: word_addr(OFS_DATA_LEN), data: chunk};
        if (acc_done) state_d = S_SEND;
      end
      S_SEND: begin
        acc = '{wr: 1'b1, addr: word_addr(OFS_ENG_CMD), data: CMD_SEND};
        if (acc_done) state_d = S_SEND_BUSY;
      end
      S_SEND_BUSY: begin
        // never abandoned: a send in flight must finish before any exit
        acc.addr = word_addr(OFS_ENG_CMD);
        if (acc_done && !busy_rd) begin
          if (!last_q) state_d = S_TDL;
          else if (!is_dpx) state_d = S_CLOSE;
          else if (active_q) state_d = S_RX_WAIT;
          else state_d = S_CONN_OFF;
        end
      end
      S_CLOSE: begin
        acc = '{wr: 1'b1, addr: word_addr(OFS_ENG_CMD), data: CMD_CLOSE};
        if (acc_done) state_d = S_FINISH;
      end
      S_RX_WAIT: begin
        acc.addr = word_addr(OFS_RX_LEN);
        if (stop) begin
          acc_need = 1'b0;
          state_d = S_IDLE;
        end else if (acc_done && rx_match) begin
          state_d = S_FCLOSE;
        end
      end
      S_FCLOSE: begin
        acc = '{wr: 1'b1, addr: word_addr(OFS_USER_CMD), data: UCMD_CLOSE};
        if (acc_done) state_d = S_CONN_OFF;
      end
      S_CONN_OFF: begin
        if (stop) begin
          acc_need = 1'b0;
          state_d = S_IDLE;
        end else if (acc_done && !conn_rd) begin
          state_d = S_FIFO;
        end
      end
      S_FIFO: begin
        acc.addr = word_addr(OFS_FIFO_STS);
        if (stop) begin
          acc_need = 1'b0;
          state_d = S_IDLE;
        end else if (acc_done && fifo_zero) begin
          state_d = S_RXLEN;
        end
      end
      S_RXLEN: begin
        acc.addr = word_addr(OFS_RX_LEN);
        if (acc_done) state_d = rx_match ? S_VERR : S_FINISH;
      end
      S_VERR: begin
        if (acc_done) state_d = S_FINISH;
      end
      S_FINISH: begin
        acc_need = 1'b0;
        state_d = (is_dpx && !cancel_q) ? S_T_TXLEN : S_IDLE;
      end
      default: begin
        acc_need = 1'b0;
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= S_LINK;
      issued_q <= 1'b0;
    end else begin
      state_q <= state_d;
      issued_q <= (issued_q || acc_start) && !acc_done;
    end
  end

  // orders from software; sizes are frozen while a test runs
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      op_q <= OP_NONE;
      active_q <= 1'b0;
      verify_q <= 1'b0;
      cancel_q <= 1'b0;
      size_q <= '0;
      pkt_q <= '0;
    end else begin
      if (go) begin
        op_q <= req_op;
        active_q <= sw_wdata[CTRL_ACTIVE];
        verify_q <= sw_wdata[CTRL_VERIFY];
      end
      cancel_q <= !go && (cancel_q || (sw_ctrl_wr && sw_wdata[CTRL_CANCEL] && !idle));
      if (sw_wr && idle && sw_addr == SW_SIZE_LO) size_q[31:0] <= sw_wdata;
      if (sw_wr && idle && sw_addr == SW_SIZE_HI) size_q[SIZE_W-1:32] <= sw_wdata[SIZE_W-33:0];
      if (sw_wr && idle && sw_addr == SW_PKT) pkt_q <= sw_wdata[15:0];
    end
  end

  // progress and results of the running test
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      linked_q <= 1'b0;
      ready_q <= 1'b0;
      conn_q <= 1'b0;
      err_q <= 1'b0;
      done_q <= 1'b0;
      rx_len_q <= '0;
      remain_q <= '0;
      loops_q <= '0;
      last_q <= 1'b0;
      pidx_q <= PARAM_FIRST;
    end else begin
      if (state_q == S_LINK && acc_done && acc_rd[BIT_LINK]) linked_q <= 1'b1;
      if (state_q == S_I_BUSY && acc_done && !busy_rd) ready_q <= 1'b1;
      else if (go && req_op == OP_INIT) ready_q <= 1'b0;
      if (acc_done && !acc.wr && acc.addr == word_addr(OFS_USER_CMD)) conn_q <= conn_rd;
      if (go) err_q <= !args_ok;
      else if (state_q == S_RXLEN && acc_done && !rx_match) err_q <= 1'b1;
      else if (state_q == S_VERR && acc_done && acc_rd[BIT_VERR]) err_q <= 1'b1;
      done_q <= !go && (done_q || (state_q == S_FINISH && state_d == S_IDLE));
      if (acc_done && (state_q == S_RXLEN || state_q == S_RX_WAIT)) rx_len_q <= acc_rd;
      if (state_q == S_PKL && acc_done) begin
        remain_q <= size_q;
        loops_q <= '0;
      end else if (state_q == S_TDL && acc_done) begin
        remain_q <= remain_q - SIZE_W'(chunk);
        loops_q <= loops_q + 32'h0000_0001;
        last_q <= split_last;
      end
      if (state_q == S_I_ERST) pidx_q <= PARAM_FIRST;
      else if (state_q == S_I_PARAM && acc_done) pidx_q <= pidx_q + 4'h1;
    end
  end

  // engine parameter shadows, written by software only while idle
  always_ff @(posedge core_clk) begin
    if (sw_wr && idle && sw_param) param_mem[sw_addr[5:2]] <= sw_wdata;
  end

  wire logic busy = !idle && state_q != S_LINK;
  wire logic [31:0] status = {16'h0000, 3'b000, state_q, 2'b00, conn_q, ready_q,
    linked_q, err_q, done_q, busy};
  wire logic [31:0] ctrl_rd = {26'h000_0000, verify_q, active_q, 1'b0, op_q};
  wire logic [31:0] rd_mux = sw_param ? param_mem[sw_addr[5:2]]
    : sw_addr == SW_CTRL ? ctrl_rd
    : sw_addr == SW_STATUS ? status
    : sw_addr == SW_SIZE_LO ? size_q[31:0]
    : sw_addr == SW_SIZE_HI ? 32'(size_q >> 32)
    : sw_addr == SW_PKT ? {16'h0000, pkt_q}
    : sw_addr == SW_RXLEN ? rx_len_q
    : sw_addr == SW_LOOPS ? loops_q : '0;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) sw_rdata_q <= '0;
    else sw_rdata_q <= sw_rd ? rd_mux : '0;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_eng_held;
    state_q == S_I_ERST && acc_done;
  endsequence
  sequence s_params_run;
    state_q == S_I_PARAM [*2];
  endsequence

  AST_LINK_FIRST: assert property (acc_start && acc.wr |-> linked_q)
    else $error("device write before link up");
  AST_READY_FIRST: assert property (state_q == S_T_URST |-> ready_q)
    else $error("test started before engine ready");
  AST_INIT_ORDER: assert property (s_eng_held |=> s_params_run)
    else $error("parameters not written after engine reset");
  AST_INIT_RELEASE: assert property (state_q == S_I_EREL && acc_start
    |-> acc.data == RST_RELEASE && $past(state_q) == S_I_PARAM)
    else $error("engine reset released out of order");
  AST_INVALID_IDLE: assert property (go && !args_ok
    |=> (state_q == S_IDLE && !dev_q.wr_en) [*3])
    else $error("invalid request caused activity");
  AST_SEND_START: assert property (state_q == S_T_UCMD && acc_start && op_q == OP_SEND
    |=> dev_q.wr_en && dev_q.addr == word_addr(OFS_USER_CMD) && dev_q.wr_data == UCMD_TX_START)
    else $error("send start command wrong");
  AST_OPEN_CMD: assert property (state_q == S_OPEN && acc_start
    |=> dev_q.wr_en && dev_q.addr == word_addr(OFS_ENG_CMD) && dev_q.wr_data == CMD_OPEN)
    else $error("active open command wrong");
  AST_PASSIVE_OPEN: assert property ($rose(state_q == S_CONN_ON) && !active_q
    |-> $past(state_q) == S_T_UCMD)
    else $error("open command in passive mode");
  AST_LOOP_SIZE: assert property (state_q == S_TDL && acc_start
    |-> acc.data <= LOOP_MAX && (split_last || is_dpx || acc.data == LOOP_MAX))
    else $error("loop size out of range");
  AST_LOOP_AFTER_BUSY: assert property ($rose(state_q == S_TDL)
    |-> $past(state_q) == S_PKL || ($past(state_q) == S_SEND_BUSY && !$past(busy_rd)))
    else $error("next loop before engine idle");
  AST_DPX_ALIGN: assert property (state_q == S_TDL && acc_start && is_dpx && !split_last
    |-> acc.data % {16'h0000, pkt_q} == '0)
    else $error("duplex loop not packet aligned");
  AST_FIFO_DRAINED: assert property ($rose(state_q == S_RXLEN) |-> $past(fifo_zero))
    else $error("length read before fifo drained");
endmodule : tos_sequencer

// ===== test/tos_dev_model.sv
// tos_dev_model: engine and user register block behind the register port
// assumes one access at a time, each read answered one cycle after its request
module tos_dev_model import tos_pkg::*; (
  input wire logic core_clk,
  input wire logic resetn,
  input wire tos_dev_t dev,
  input wire logic link,
  input wire logic peer_set,
  input wire logic peer_clr,
  input wire logic verr,
  input wire logic [31:0] rx_qw,
  output logic rd_valid_q,
  output logic [31:0] rd_data_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rst_q, conn_q, urst_q, verr_q;
  logic [7:0] busy_q;
  logic [3:0] fifo_q;
  logic [31:0] rxlen_q, rd_mux;
  wire logic [11:0] a = dev.addr;
  wire logic wr = dev.wr_en;
  always_comb begin
    case (a)
      12'h001: rd_mux = {31'h0, rst_q | (busy_q != 8'h00)};
      12'h401: rd_mux = {29'h0, conn_q, verr_q, 1'b0};
      12'h402: rd_mux = {15'h0, link, 15'h0, urst_q};
      12'h403: rd_mux = {28'h0, fifo_q};
      12'h404: rd_mux = rxlen_q;
      default: rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      {conn_q, urst_q, verr_q, busy_q, fifo_q, rxlen_q} <= '0;
      rst_q <= 1'b1;
      rd_valid_q <= 1'b0;
      rd_data_q <= 32'h0;
    end else begin
      urst_q <= wr && a == 12'h402 && dev.wr_data[0];
      busy_q <= (busy_q != 8'h00) ? busy_q - 8'h01 : 8'h00;
      fifo_q <= (fifo_q != 4'h0) ? fifo_q - 4'h1 : 4'h0;
      verr_q <= verr_q | verr;
      if (peer_set) begin
        conn_q <= 1'b1;
        rxlen_q <= rx_qw;
      end
      if (peer_clr) begin
        conn_q <= 1'b0;
        // long enough that the drain poll really has to wait
        fifo_q <= 4'hF;
      end
      if (wr && a == 12'h000) begin
        rst_q <= dev.wr_data[0];
        busy_q <= dev.wr_data[0] ? 8'h00 : 8'h28;
      end
      if (wr && a == 12'h001) begin
        if (dev.wr_data[1:0] == 2'h0) busy_q <= 8'h14;
        if (dev.wr_data[1:0] == 2'h2) conn_q <= 1'b1;
        if (dev.wr_data[1:0] == 2'h3) conn_q <= 1'b0;
      end
      if (wr && a == 12'h401) begin
        rxlen_q <= 32'h0;
        verr_q <= 1'b0;
      end
      rd_valid_q <= dev.rd_req;
      // outside an answer the data toggles so a stale sample is never taken for valid
      rd_data_q <= dev.rd_req ? rd_mux : ~rd_data_q;
    end
  end
endmodule : tos_dev_model

// ===== test/tb.sv
// tb: self-checking bench for the offload test sequencer
// assumes the device model stands on the register port of the sequencer
module tb import tos_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, resetn, sw_wr, sw_rd, link, peer_set, peer_clr, verr, rd_valid;
  logic [7:0] sw_addr;
  logic [31:0] sw_wdata, sw_rdata_q, rx_qw, rd_data, rnd, st;
  logic [31:0] prm [16];
  logic [47:0] sz;
  logic [15:0] pk;
  tos_dev_t dev_q;
  logic [43:0] log_q [$];
  logic [43:0] exp_q [$];
  int failures, checked;
  tos_sequencer dut_u (.core_clk(core_clk), .resetn(resetn), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata_q(sw_rdata_q),
    .dev_q(dev_q), .dev_rd_valid(rd_valid), .dev_rd_data(rd_data));
  tos_dev_model dev_u (.core_clk(core_clk), .resetn(resetn), .dev(dev_q), .link(link),
    .peer_set(peer_set), .peer_clr(peer_clr), .verr(verr), .rx_qw(rx_qw),
    .rd_valid_q(rd_valid), .rd_data_q(rd_data));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (dev_q.wr_en === 1'b1) log_q.push_back({dev_q.addr, dev_q.wr_data});
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic chk(input logic [43:0] seen, input logic [43:0] want);
    checked++;
    if (seen !== want) begin
      failures++;
      $display("ERROR %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic swr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge core_clk);
    sw_wr <= 1'b0;
  endtask : swr
  task automatic srd(input logic [7:0] a);
    @(posedge core_clk);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge core_clk);
    sw_rd <= 1'b0;
    #1 st = sw_rdata_q;
  endtask : srd
  task automatic wait_done();
    for (int i = 0; i < 4000; i++) begin
      srd(SW_STATUS);
      if (st[1] === 1'b1) break;
    end
    chk(44'(st[1]), 44'h1);
  endtask : wait_done
  task automatic go(input logic [31:0] ctrl);
    log_q.delete();
    exp_q.delete();
    swr(SW_CTRL, ctrl);
  endtask : go
  task automatic ex(input logic [15:0] ofs, input logic [31:0] d);
    exp_q.push_back({ofs[13:2], d});
  endtask : ex
  task automatic cmp_log(input logic whole);
    if (whole) chk(44'(log_q.size()), 44'(exp_q.size()));
    foreach (exp_q[i]) chk(log_q[i], exp_q[i]);
  endtask : cmp_log
  task automatic setsz();
    swr(SW_SIZE_LO, sz[31:0]);
    swr(SW_SIZE_HI, {16'h0, sz[47:32]});
    swr(SW_PKT, {16'h0, pk});
  endtask : setsz
  task automatic peer(input int gap, input logic cl);
    repeat (gap) @(posedge core_clk);
    peer_set <= !cl;
    peer_clr <= cl;
    @(posedge core_clk);
    peer_set <= 1'b0;
    peer_clr <= 1'b0;
  endtask : peer
  task automatic exp_xfer(input logic [31:0] uc, input logic act, input logic aln);
    logic [47:0] rem;
    logic [31:0] c, mx;
    mx = aln ? LOOP_MAX - LOOP_MAX % pk : LOOP_MAX;
    ex(OFS_TX_LEN, sz[34:3]);
    ex(OFS_USER_RST, RST_PULSE);
    ex(OFS_USER_CMD, uc);
    if (act) ex(OFS_ENG_CMD, CMD_OPEN);
    ex(OFS_PKT_LEN, {16'h0, pk});
    rem = sz;
    while (rem != 48'h0) begin
      c = (rem > 48'(mx)) ? mx : rem[31:0];
      ex(OFS_DATA_LEN, c);
      ex(OFS_ENG_CMD, CMD_SEND);
      rem = rem - 48'(c);
    end
  endtask : exp_xfer
  initial begin
    repeat (60000) @(posedge core_clk);
    failures++;
    close_out();
  end
  initial begin
    {sw_wr, sw_rd, link, peer_set, peer_clr, verr} = '0;
    sw_addr = 8'h00;
    sw_wdata = 32'h0;
    rx_qw = 32'h0;
    rnd = 32'h0000_001F;
    resetn = 1'b0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (30) @(posedge core_clk);
    srd(SW_STATUS);
    chk(st[3], 1'b0);
    link <= 1'b1;
    repeat (20) @(posedge core_clk);
    srd(SW_STATUS);
    chk(st[3], 1'b1);
    $display("link test done");
    go(32'h2);
    srd(SW_STATUS);
    chk(st[2], 1'b1);
    repeat (10) @(posedge core_clk);
    cmp_log(1'b1);
    $display("refusal test done");
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr_next(rnd);
      prm[i] = rnd;
      swr(SW_PARAM + 8'(4 * i), rnd);
    end
    go(32'h1);
    wait_done();
    chk(st[4], 1'b1);
    ex(OFS_USER_RST, RST_PULSE);
    ex(OFS_ENG_RST, RST_PULSE);
    for (int i = 2; i < 15; i++) ex(16'(4 * i), prm[i]);
    ex(OFS_ENG_RST, RST_RELEASE);
    cmp_log(1'b1);
    $display("init test done");
    for (int k = 0; k < 2; k++) begin
      rnd = lfsr_next(rnd);
      sz = (k == 1) ? 48'h0001_0000_0010 : {37'h0, rnd[7:0], 3'b000} + 48'h8;
      pk = rnd[23:8] | 16'h0001;
      setsz();
      go(32'hA);
      wait_done();
      chk(st[2], 1'b0);
      exp_xfer(UCMD_TX_START, 1'b1, 1'b0);
      ex(OFS_ENG_CMD, CMD_CLOSE);
      cmp_log(1'b1);
      srd(SW_LOOPS);
      chk(st, 32'(k + 1));
    end
    $display("send test done");
    sz = 48'h0000_0000_0400;
    pk = 16'h0000;
    setsz();
    for (int k = 0; k < 3; k++) begin
      rx_qw = 32'h80 + 32'(k == 1);
      verr <= (k == 2);
      go({28'h000_0001, k == 0, 3'h3});
      peer(40, 1'b0);
      peer(40, 1'b1);
      wait_done();
      chk(st[2], k != 0);
      ex(OFS_USER_RST, RST_PULSE);
      ex(OFS_USER_CMD, UCMD_DPX_VER);
      if (k == 0) ex(OFS_ENG_CMD, CMD_OPEN);
      cmp_log(1'b1);
      srd(SW_RXLEN);
      chk(st, rx_qw);
    end
    verr <= 1'b0;
    $display("receive test done");
    rnd = lfsr_next(rnd);
    pk = rnd[15:0] | 16'h0100;
    sz = 48'h0001_0000_0010;
    rx_qw = 32'h2000_0002;
    setsz();
    go(32'h4);
    peer(40, 1'b0);
    repeat (300) @(posedge core_clk);
    peer(0, 1'b1);
    repeat (300) @(posedge core_clk);
    exp_xfer(UCMD_DPX, 1'b0, 1'b1);
    ex(OFS_TX_LEN, sz[34:3]);
    ex(OFS_USER_RST, RST_PULSE);
    ex(OFS_USER_CMD, UCMD_DPX);
    cmp_log(1'b1);
    swr(SW_CTRL, 32'h20);
    repeat (20) @(posedge core_clk);
    srd(SW_STATUS);
    chk(st[2:0], 3'b000);
    $display("duplex test done");
    close_out();
  end
endmodule : tb
